// >>> design/cwr_ctrl.sv
// configuration register file, write restart control, conversion pacing, serial framing,
// read checksum and background configuration checksum
// assumes a command decoder outside turning serial bytes into whole-register writes
// Notes on behaviour
// R1: writes to digital-only, unused or key bits never disturb a running conversion
// R2: immediate group resets at once; new conversion after two master clocks
// R3: run state, divider, ratio, gain, chopper, cal enables, selector, wait restart at once
// R4: cal enables restart only on change; cal values only while enabled
// R5: in sequenced mode these restarts, except run state and wait writes, keep sequence position and cycle
// R6: selector writes ignored while sequencing
// R7: inter-conversion wait writes ignored in single-input mode
// R8: run state 11 restarts conversion or whole sequence; other values stop
// R9: changed power/clock or reserved writes reset, then warm-up after two clocks
// R10: delayed group launches warm-up even in standby
// R11: restart resets clock phases, waits two to four clocks for alignment
// R12: host should avoid reconfiguring during conversions if clock output matters
// R13: single-input mode ignores scan writes unless sequencing is enabled
// R14: in a sequence cycle channel writes restart sequence, interval writes do not
// R15: in the gap interval writes restart sequence, channel writes do not
// R16: modes 0,0 and 1,1; sample on rising, launch on falling serial clock
// R17: chip select high floats output, ignores clock; its rise resets framing
// R18: host changes clock polarity only while chip select is high
// R19: serial logic held in reset during power-on reset
// R20: external clock selected: serial clock paces conversion; else may output clock
// R21: writes other than to the key rejected unless the key equals a5
// R22: reads append a sixteen-bit checksum when enabled
// R23: while locked a background checksum runs, is readable, flags changes
// R24: warm-up lasts 256 filter clocks before converting
// R25: divider, ratio, gain, chopper, cal and selector restarts only while not idle (warm-up, delay and gap included); idle writes to them just store
`timescale 1ns/1ps
`include "cwr_regs.svh"
module cwr_ctrl import cwr_pkg::*; (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // serial pins
  input  wire cwr_spi_t    spi,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             sck_out,
  output logic             sck_oe,
  // byte link to the command decoder
  output logic [7:0]       rx_byte,
  output logic             rx_vld,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_end,
  // register access from the command decoder
  input  wire cwr_wr_t     wr,
  output logic             wr_ok,
  input  wire logic [3:0]  rd_addr,
  output logic [23:0]      rd_data,
  // conversion status
  output logic             conv_on,
  output logic             drdy,
  output logic [3:0]       seq_pos,
  output logic [15:0]      seq_cycle,
  // background checksum
  output logic [15:0]      crc_value,
  output logic             crc_flag,
  input  wire logic        crc_flag_clr
);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CWR_CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) r = crc_step(r, b[i]);
    crc_byte = r;
  endfunction

  // lowest set channel above pos (or from zero when first is set)
  function automatic logic [4:0] next_ch(input logic [15:0] sel, input logic [3:0] pos,
                                         input logic first);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (sel[i] && (first || i > int'(pos))) r = {1'b1, 4'(i)};
    end
    next_ch = r;
  endfunction

  logic [23:0] regs_r [`CWR_A_FIRST:`CWR_A_LAST];
  logic [23:0] regs_nxt [`CWR_A_FIRST:`CWR_A_LAST];
  cwr_state_t  st_r, st_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  logic [2:0]  rw_r, rw_nxt;
  logic        warm_r, warm_nxt;
  logic [4:0]  ph_r, ph_nxt;
  logic        sck_q_r;
  logic        cs_q_r;
  logic        mt, dm, locked, scan_on, run_on, active;
  logic [4:0]  per;
  logic        acc, chg, do_dly, do_rst, do_seq, do_stop;
  logic [23:0] old_v;

  // master clock tick: serial clock rises when the external clock is chosen
  assign mt = (regs_r[`CWR_A_CFG0][5] == `CWR_CLK_EXT) ? (spi.sck && !sck_q_r) : 1'b1; // R20
  assign per = `CWR_DM_PER_BASE << regs_r[`CWR_A_CFG1][`CWR_F_PRE];
  assign dm = mt && (ph_r == per - 5'h01);
  assign locked = regs_r[`CWR_A_LOCK][`CWR_F_KEY] != `CWR_KEY_OPEN;
  assign scan_on = |regs_r[`CWR_A_SCAN][`CWR_F_CHSEL];
  assign run_on = regs_r[`CWR_A_CFG0][`CWR_F_RUN] == `CWR_RUN_CONV;
  assign active = st_r != CV_IDLE; // R25

  // write acceptance and restart classification
  always_comb begin
    for (int i = `CWR_A_FIRST; i <= `CWR_A_LAST; i++) regs_nxt[i] = regs_r[i];
    acc = wr.vld && wr.addr >= `CWR_A_FIRST && wr.addr <= `CWR_A_LAST
          && (!locked || wr.addr == `CWR_A_LOCK); // R21
    old_v = acc ? regs_r[wr.addr] : 24'h000000;
    chg = old_v != wr.data;
    do_dly = 1'b0;
    do_rst = 1'b0;
    do_seq = 1'b0;
    do_stop = 1'b0;
    if (acc) begin
      regs_nxt[wr.addr] = wr.data;
      case (wr.addr)
        `CWR_A_CFG0: begin
          do_dly = chg; // R9 R10
          if (wr.data[`CWR_F_RUN] == `CWR_RUN_CONV) begin
            do_rst = 1'b1; // R8
            do_seq = scan_on;
          end else begin
            do_stop = 1'b1;
          end
        end
        `CWR_A_RSVB, `CWR_A_RSVC: do_dly = chg; // R9
        `CWR_A_CFG1, `CWR_A_CFG2: do_rst = active; // R3
        `CWR_A_CFG3: do_rst = active && (wr.data[`CWR_F_OFFEN] != old_v[`CWR_F_OFFEN]
                                 || wr.data[`CWR_F_GAINEN] != old_v[`CWR_F_GAINEN]); // R4
        `CWR_A_MUX: do_rst = active && !scan_on; // R6
        `CWR_A_SCAN: begin
          if (scan_on) begin
            do_rst = active && st_r != CV_GAP; // R14 R15
          end else begin
            do_rst = run_on && |wr.data[`CWR_F_CHSEL]; // R7 R13
          end
          do_seq = do_rst;
        end
        `CWR_A_TIMER: begin
          do_rst = scan_on && st_r == CV_GAP; // R13 R14 R15
          do_seq = do_rst;
        end
        `CWR_A_OFFS: do_rst = active && regs_r[`CWR_A_CFG3][`CWR_F_OFFEN]; // R4
        `CWR_A_GAIN: do_rst = active && regs_r[`CWR_A_CFG3][`CWR_F_GAINEN]; // R4
        default: do_rst = 1'b0; // R1
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = `CWR_A_FIRST; i <= `CWR_A_LAST; i++) regs_r[i] <= `CWR_RST_OTHER;
      regs_r[`CWR_A_IRQ] <= `CWR_RST_IRQ;
      regs_r[`CWR_A_LOCK] <= `CWR_RST_LOCK;
      wr_ok <= 1'b0;
      rd_data <= 24'h000000;
    end else begin
      for (int i = `CWR_A_FIRST; i <= `CWR_A_LAST; i++) regs_r[i] <= regs_nxt[i];
      wr_ok <= acc;
      if (rd_addr == `CWR_A_CRC) rd_data <= {8'h00, crc_value}; // R23
      else if (rd_addr >= `CWR_A_FIRST && rd_addr <= `CWR_A_LAST) rd_data <= regs_r[rd_addr];
      else rd_data <= 24'h000000;
    end
  end

  // conversion pacing
  logic [4:0]  nx;
  logic [4:0]  fx;
  logic [15:0] cyc_nxt;
  logic [3:0]  pos_nxt;
  logic        drdy_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rw_nxt = rw_r;
    warm_nxt = warm_r;
    pos_nxt = seq_pos;
    cyc_nxt = seq_cycle;
    drdy_nxt = 1'b0;
    ph_nxt = !mt ? ph_r : (ph_r == per - 5'h01) ? 5'h00 : ph_r + 5'h01;
    nx = next_ch(regs_r[`CWR_A_SCAN][`CWR_F_CHSEL], seq_pos, 1'b0);
    fx = next_ch(regs_nxt[`CWR_A_SCAN][`CWR_F_CHSEL], seq_pos, 1'b1);
    case (st_r)
      CV_RST: begin
        if (mt) rw_nxt = rw_r + 3'h1;
        // wait out the two clocks, then for divided clock alignment up to four
        if (mt && rw_r + 3'h1 >= `CWR_RESTART_MCLK
            && (ph_nxt == 5'h00 || rw_r + 3'h1 >= `CWR_RESTART_MAX)) begin // R2 R11
          cnt_nxt = 24'h000000;
          st_nxt = warm_r ? CV_WARM : run_on ? CV_CONV : CV_IDLE;
        end
      end
      CV_WARM: begin
        if (dm) cnt_nxt = cnt_r + 24'h000001;
        if (dm && cnt_r + 24'h000001 >= `CWR_WARMUP_DIGITAL_FILTER_CLOCK) begin // R24
          cnt_nxt = 24'h000000;
          st_nxt = run_on ? CV_CONV : CV_IDLE;
        end
      end
      CV_CONV: begin
        if (dm) cnt_nxt = cnt_r + 24'h000001;
        if (dm && cnt_r + 24'h000001 >= (`CWR_CONV_BASE << regs_r[`CWR_A_CFG1][`CWR_F_OSR])) begin
          drdy_nxt = 1'b1;
          cnt_nxt = 24'h000000;
          if (scan_on && nx[4]) begin
            pos_nxt = nx[3:0];
            st_nxt = (regs_r[`CWR_A_SCAN][`CWR_F_DLY] == 3'h0) ? CV_CONV : CV_DLY;
          end else if (scan_on) begin
            pos_nxt = fx[3:0];
            cyc_nxt = seq_cycle + 16'h0001;
            cnt_nxt = regs_r[`CWR_A_TIMER];
            st_nxt = (regs_r[`CWR_A_TIMER] == 24'h000000) ? CV_CONV : CV_GAP;
          end else if (regs_r[`CWR_A_CFG3][`CWR_F_CMODE] != `CWR_CMODE_CONT) begin
            st_nxt = CV_IDLE;
          end
        end
      end
      CV_DLY: begin
        if (dm) cnt_nxt = cnt_r + 24'h000001;
        if (dm && cnt_r + 24'h000001 >= (`CWR_DLY_BASE << regs_r[`CWR_A_SCAN][`CWR_F_DLY])) begin
          cnt_nxt = 24'h000000;
          st_nxt = CV_CONV;
        end
      end
      CV_GAP: begin
        if (dm) cnt_nxt = cnt_r - 24'h000001;
        if (dm && cnt_r == 24'h000001) begin
          cnt_nxt = 24'h000000;
          st_nxt = CV_CONV;
        end
      end
      default: st_nxt = CV_IDLE;
    endcase
    // a write reset takes effect at once and overrides the pacing above
    if (do_dly || do_rst) begin
      st_nxt = CV_RST; // R2 R9
      rw_nxt = 3'h0;
      ph_nxt = 5'h00; // R11
      warm_nxt = do_dly; // R10
      if (do_seq) begin
        pos_nxt = fx[3:0]; // R8
        cyc_nxt = 16'h0000;
      end // R5
    end else if (do_stop) begin
      st_nxt = CV_IDLE; // R8
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= CV_IDLE;
      cnt_r <= 24'h000000;
      rw_r <= 3'h0;
      warm_r <= 1'b0;
      ph_r <= 5'h00;
      seq_pos <= 4'h0;
      seq_cycle <= 16'h0000;
      drdy <= 1'b0;
      conv_on <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rw_r <= rw_nxt;
      warm_r <= warm_nxt;
      ph_r <= ph_nxt;
      seq_pos <= pos_nxt;
      seq_cycle <= cyc_nxt;
      drdy <= drdy_nxt;
      conv_on <= st_nxt == CV_CONV;
    end
  end

  // serial framing; chip select high resets bit count, byte phase and checksum and floats sdo
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  rxs_r, rxs_nxt, txs_r, txs_nxt;
  logic [15:0] tcrc_r, tcrc_nxt;
  logic [1:0]  tph_r, tph_nxt;
  logic        bdone_r, bdone_nxt;
  logic        sdo_nxt, oe_nxt, rxv_nxt;
  logic [7:0]  rxb_nxt;
  logic        load;
  always_comb begin
    bit_nxt = bit_r;
    rxs_nxt = rxs_r;
    txs_nxt = txs_r;
    tcrc_nxt = tcrc_r;
    tph_nxt = tph_r;
    bdone_nxt = bdone_r;
    sdo_nxt = sdo;
    oe_nxt = 1'b1;
    rxv_nxt = 1'b0;
    rxb_nxt = rx_byte;
    load = 1'b0;
    if (spi.cs_n) begin
      bit_nxt = 3'h0; // R17
      bdone_nxt = 1'b0;
      tph_nxt = 2'h0;
      tcrc_nxt = `CWR_CRC_INIT;
      oe_nxt = 1'b0;
    end else begin
      if (spi.sck && !sck_q_r) begin
        rxs_nxt = {rxs_r[6:0], spi.sdi}; // R16
        bit_nxt = bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          rxb_nxt = {rxs_r[6:0], spi.sdi};
          rxv_nxt = 1'b1;
          bdone_nxt = 1'b1;
        end
      end
      load = cs_q_r || (!spi.sck && sck_q_r && bdone_r);
      if (load) begin
        bdone_nxt = 1'b0;
        if (tph_r == 2'h0 && tx_end && regs_r[`CWR_A_CFG3][`CWR_F_LNKCRC]) begin
          txs_nxt = tcrc_r[15:8]; // R22
          tph_nxt = 2'h1;
        end else if (tph_r == 2'h1) begin
          txs_nxt = tcrc_r[7:0];
          tph_nxt = 2'h2;
        end else if (tph_r == 2'h0) begin
          txs_nxt = tx_byte;
          tcrc_nxt = crc_byte(tcrc_r, tx_byte);
        end else begin
          txs_nxt = 8'h00;
        end
        sdo_nxt = txs_nxt[7];
      // a fall ahead of the first rise (idle-high clock) must keep the first bit in place
      end else if (!spi.sck && sck_q_r && bit_r != 3'h0) begin
        txs_nxt = {txs_r[6:0], 1'b0}; // R16
        sdo_nxt = txs_r[6];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin // R19
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b0;
      bit_r <= 3'h0;
      rxs_r <= 8'h00;
      txs_r <= 8'h00;
      tcrc_r <= `CWR_CRC_INIT;
      tph_r <= 2'h0;
      bdone_r <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      rx_byte <= 8'h00;
      rx_vld <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      sck_q_r <= spi.sck;
      cs_q_r <= spi.cs_n;
      bit_r <= bit_nxt;
      rxs_r <= rxs_nxt;
      txs_r <= txs_nxt;
      tcrc_r <= tcrc_nxt;
      tph_r <= tph_nxt;
      bdone_r <= bdone_nxt;
      sdo <= sdo_nxt;
      sdo_oe <= oe_nxt;
      rx_byte <= rxb_nxt;
      rx_vld <= rxv_nxt;
      // divided clock out only with the internal oscillator and while deselected
      sck_out <= ph_nxt[regs_r[`CWR_A_CFG1][`CWR_F_PRE]];
      sck_oe <= spi.cs_n && regs_r[`CWR_A_CFG0][`CWR_F_CLKSEL] == `CWR_CLK_AMOUT; // R20
    end
  end

  // background checksum, one register per master clock tick while locked
  logic [3:0]  bidx_r, bidx_nxt;
  logic [15:0] bacc_r, bacc_nxt, crc_nxt, bsum;
  logic        bval_r, bval_nxt, flag_nxt, bset;
  always_comb begin
    bidx_nxt = bidx_r;
    bacc_nxt = bacc_r;
    bval_nxt = bval_r;
    crc_nxt = crc_value;
    bset = 1'b0;
    bsum = crc_byte(crc_byte(crc_byte(bacc_r, regs_r[bidx_r][23:16]),
                             regs_r[bidx_r][15:8]), regs_r[bidx_r][7:0]);
    if (!locked) begin
      bidx_nxt = `CWR_A_FIRST;
      bacc_nxt = `CWR_CRC_INIT;
      bval_nxt = 1'b0;
    end else if (mt) begin // R23
      bidx_nxt = bidx_r + 4'h1;
      bacc_nxt = bsum;
      if (bidx_r == `CWR_A_LAST) begin
        bidx_nxt = `CWR_A_FIRST;
        bacc_nxt = `CWR_CRC_INIT;
        crc_nxt = bsum;
        bset = bval_r && bsum != crc_value;
        bval_nxt = 1'b1;
      end
    end
    flag_nxt = bset || (crc_flag && !crc_flag_clr); // R23
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bidx_r <= `CWR_A_FIRST;
      bacc_r <= `CWR_CRC_INIT;
      bval_r <= 1'b0;
      crc_value <= `CWR_CRC_INIT;
      crc_flag <= 1'b0;
    end else begin
      bidx_r <= bidx_nxt;
      bacc_r <= bacc_nxt;
      bval_r <= bval_nxt;
      crc_value <= crc_nxt;
      crc_flag <= flag_nxt;
    end
  end

endmodule

// >>> design/cwr_regs.svh
// register indices, field positions, reset values and counts for the restart controller
// included by the package user; definitions only
`ifndef CWR_REGS_SVH
`define CWR_REGS_SVH
`define CWR_A_CFG0      4'h1
`define CWR_A_CFG1      4'h2
`define CWR_A_CFG2      4'h3
`define CWR_A_CFG3      4'h4
`define CWR_A_IRQ       4'h5
`define CWR_A_MUX       4'h6
`define CWR_A_SCAN      4'h7
`define CWR_A_TIMER     4'h8
`define CWR_A_OFFS      4'h9
`define CWR_A_GAIN      4'ha
`define CWR_A_RSVB      4'hb
`define CWR_A_RSVC      4'hc
`define CWR_A_LOCK      4'hd
`define CWR_A_CRC       4'hf
`define CWR_A_FIRST     4'h1
`define CWR_A_LAST      4'hd
// field positions
`define CWR_F_RUN       1:0
`define CWR_F_CLKSEL    5:4
`define CWR_F_PRE       7:6
`define CWR_F_OSR       5:2
`define CWR_F_CMODE     7:6
`define CWR_F_LNKCRC    2
`define CWR_F_OFFEN     1
`define CWR_F_GAINEN    0
`define CWR_F_DLY       23:21
`define CWR_F_CHSEL     15:0
`define CWR_F_KEY       7:0
// values
`define CWR_RUN_CONV    2'h3
`define CWR_CMODE_CONT  2'h3
`define CWR_CLK_EXT     1'h0
`define CWR_CLK_AMOUT   2'h3
`define CWR_KEY_OPEN    8'ha5
`define CWR_RST_LOCK    24'h0000a5
`define CWR_RST_IRQ     24'h000002
`define CWR_RST_OTHER   24'h000000
// timing in master clocks / filter clocks
`define CWR_RESTART_MCLK 3'h2
`define CWR_RESTART_MAX  3'h4
`define CWR_WARMUP_DIGITAL_FILTER_CLOCK 24'h000100
`define CWR_CONV_BASE    24'h000020
`define CWR_DLY_BASE     24'h000004
`define CWR_DM_PER_BASE  5'h04
// checksum
`define CWR_CRC_POLY    16'h8005
`define CWR_CRC_INIT    16'h0000
`endif

// >>> design/cwr_pkg.sv
// types shared by the configuration-write restart controller
// constants live in cwr_regs.svh
package cwr_pkg;
  typedef enum logic [2:0] {CV_IDLE, CV_RST, CV_WARM, CV_CONV, CV_DLY, CV_GAP} cwr_state_t;
  typedef struct packed {
    logic        vld;
    logic [3:0]  addr;
    logic [23:0] data;
  } cwr_wr_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } cwr_spi_t;
endpackage

// >>> verif/cwr_ctrl_checker.sv
// port assertions for the configuration write restart controller
// bound to every cwr_ctrl; the unlock key is tracked here from the write port
`timescale 1ns/1ps
`include "cwr_regs.svh"
module cwr_ctrl_checker import cwr_pkg::*; (
  // clock and reset
  input wire logic     mclk,
  input wire logic     rst_n,
  // watched ports
  input wire cwr_spi_t spi,
  input wire cwr_wr_t  wr,
  input wire logic     wr_ok,
  input wire logic     sdo_oe,
  input wire logic     sck_oe,
  input wire logic     rx_vld,
  input wire logic     conv_on,
  input wire logic     drdy,
  input wire logic     crc_flag,
  input wire logic     crc_flag_clr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] key_r;
  logic [7:0] key_nxt;
  logic       take;
  // lock register stays writable so a locked part can be opened again
  assign take = wr.vld && wr.addr >= `CWR_A_FIRST && wr.addr <= `CWR_A_LAST &&
                (key_r == `CWR_KEY_OPEN || wr.addr == `CWR_A_LOCK);
  always_comb begin
    key_nxt = key_r;
    if (take && wr.addr == `CWR_A_LOCK) key_nxt = wr.data[7:0];
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) key_r <= `CWR_KEY_OPEN;
    else key_r <= key_nxt;
  end
  a_write_taken: assert property (take |=> wr_ok)
    else $error("accepted write gave no acknowledge");
  a_write_locked: assert property (wr.vld && !take |=> !wr_ok)
    else $error("refused write was acknowledged");
  a_ok_cause: assert property (wr_ok |-> $past(take))
    else $error("acknowledge without an accepted write");
  a_cs_float: assert property (spi.cs_n |=> !sdo_oe)
    else $error("output driven while deselected");
  a_cs_drive: assert property (!spi.cs_n |=> sdo_oe)
    else $error("output not driven while selected");
  a_cs_quiet: assert property (spi.cs_n |=> !rx_vld)
    else $error("byte received while deselected");
  a_clk_out: assert property (!spi.cs_n |=> !sck_oe)
    else $error("clock output driven while selected");
  a_restart_gap: assert property ($fell(conv_on) |-> !conv_on [*2])
    else $error("conversion resumed within two clocks");
  a_rx_pulse: assert property (rx_vld |=> !rx_vld)
    else $error("byte strobe longer than one cycle");
  a_flag_hold: assert property (crc_flag && !crc_flag_clr |=> crc_flag)
    else $error("checksum flag dropped without clear");
  a_drdy_pulse: assert property (drdy |=> !drdy)
    else $error("ready strobe longer than one cycle");
  c_take: cover property (take);
  c_refuse: cover property (wr.vld && !take);
  c_restart: cover property ($fell(conv_on));
  c_rx: cover property (rx_vld);
endmodule
bind cwr_ctrl cwr_ctrl_checker i_chk (.mclk(mclk), .rst_n(rst_n), .spi(spi), .wr(wr),
  .wr_ok(wr_ok), .sdo_oe(sdo_oe), .sck_oe(sck_oe), .rx_vld(rx_vld), .conv_on(conv_on),
  .drdy(drdy), .crc_flag(crc_flag), .crc_flag_clr(crc_flag_clr));

// >>> verif/cwr_host_model.sv
// serial master model standing for the host on the four-wire link
// lines change on falling mclk; serial clock half period is three mclk
`timescale 1ns/1ps
module cwr_host_model import cwr_pkg::*; (
  // clock
  input wire logic mclk,
  // serial lines
  output cwr_spi_t spi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial spi = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
  // n copies of tx go out in one frame; rx keeps the last byte seen on sdo
  task automatic xfer(input logic mode, input logic [7:0] tx, input int n,
                      output logic [7:0] rx, output logic oe);
    @(negedge mclk);
    spi.sck = mode;
    repeat (3) @(negedge mclk);
    spi.cs_n = 1'b0;
    oe = 1'b1;
    for (int i = 8 * n - 1; i >= 0; i--) begin
      repeat (3) @(negedge mclk);
      spi.sck = 1'b0;
      spi.sdi = tx[i % 8];
      repeat (3) @(negedge mclk);
      rx[i % 8] = sdo;
      oe &= sdo_oe;
      spi.sck = 1'b1;
    end
    repeat (3) @(negedge mclk);
    spi.sck = mode;
    // a released data line shows the inverse of its last level
    spi.sdi = ~tx[0];
    repeat (3) @(negedge mclk);
    spi.cs_n = 1'b1;
  endtask
endmodule

// >>> verif/test_config_write_restart_control.sv
// self-checking bench for the configuration write restart controller
// inputs change on falling mclk; the host model drives the serial pins
`timescale 1ns/1ps
`include "cwr_regs.svh"
module test_config_write_restart_control import cwr_pkg::*; ;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  cwr_spi_t    spi;
  cwr_wr_t     wr = '0;
  logic [3:0]  rd_addr = 4'h0;
  logic [7:0]  tx_byte = 8'h00;
  logic        tx_end = 1'b0;
  logic        crc_flag_clr = 1'b0;
  logic        sdo, sdo_oe, sck_out, sck_oe, rx_vld, wr_ok, conv_on, drdy, crc_flag;
  logic [7:0]  rx_byte;
  logic [23:0] rd_data;
  logic [3:0]  seq_pos;
  logic [15:0] seq_cycle, crc_value;
  int          n_errors = 0;
  int          check_count = 0;
  always #4 mclk = ~mclk;
  cwr_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .spi(spi), .sdo(sdo), .sdo_oe(sdo_oe),
    .sck_out(sck_out), .sck_oe(sck_oe), .rx_byte(rx_byte), .rx_vld(rx_vld),
    .tx_byte(tx_byte), .tx_end(tx_end), .wr(wr), .wr_ok(wr_ok), .rd_addr(rd_addr),
    .rd_data(rd_data), .conv_on(conv_on), .drdy(drdy), .seq_pos(seq_pos),
    .seq_cycle(seq_cycle), .crc_value(crc_value), .crc_flag(crc_flag),
    .crc_flag_clr(crc_flag_clr));
  cwr_host_model i_host (.mclk(mclk), .spi(spi), .sdo(sdo), .sdo_oe(sdo_oe));
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [23:0] d, output logic ok);
    @(negedge mclk);
    wr = '{vld: 1'b1, addr: a, data: d};
    @(negedge mclk);
    wr.vld = 1'b0;
    ok = wr_ok;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [23:0] d);
    @(negedge mclk);
    rd_addr = a;
    repeat (2) @(negedge mclk);
    d = rd_data;
  endtask
  // write, then count idle cycles of the converter inside a window past the bound
  task automatic measure(input logic [3:0] a, input logic [23:0] d, input int lo, input int hi);
    logic ok;
    int   n;
    n = 0;
    wreg(a, d, ok);
    check(ok, 1'b1);
    repeat (hi + 8) begin
      @(negedge mclk);
      if (conv_on !== 1'b1) n++;
    end
    check(n >= lo && n <= hi, 1'b1);
  endtask
  task automatic t_reset();
    logic [23:0] d;
    for (int a = 0; a < 15; a++) begin
      rreg(a[3:0], d);
      check(d, a == 13 ? `CWR_RST_LOCK : a == 5 ? `CWR_RST_IRQ : `CWR_RST_OTHER);
    end
    check(sdo_oe, 1'b0);
    check(conv_on, 1'b0);
    $display("t_reset done");
  endtask
  task automatic t_idle();
    logic        ok;
    logic [23:0] d;
    wreg(`CWR_A_CFG3, 24'h0000c0, ok);
    wreg(`CWR_A_CFG1, 24'h000014, ok);
    repeat (20) @(negedge mclk);
    check(conv_on, 1'b0);
    rreg(`CWR_A_CFG1, d);
    check(d, 24'h000014);
    $display("t_idle done");
  endtask
  task automatic t_start();
    measure(`CWR_A_CFG0, 24'h000033, 1024, 1040);
    check(sck_oe, 1'b1);
    $display("t_start done");
  endtask
  task automatic t_digital();
    measure(`CWR_A_CFG3, 24'h0000c4, 0, 0);
    measure(`CWR_A_LOCK, 24'h0000a5, 0, 0);
    $display("t_digital done");
  endtask
  task automatic t_immediate();
    measure(`CWR_A_CFG1, 24'h000018, 2, 5);
    measure(`CWR_A_CFG2, 24'h000001, 2, 5);
    measure(`CWR_A_MUX, 24'h000001, 2, 5);
    measure(`CWR_A_CFG0, 24'h000033, 2, 5);
    measure(`CWR_A_SCAN, 24'h200000, 0, 0);
    measure(`CWR_A_TIMER, 24'h000005, 0, 0);
    $display("t_immediate done");
  endtask
  task automatic t_cal();
    measure(`CWR_A_OFFS, 24'h000001, 0, 0);
    measure(`CWR_A_CFG3, 24'h0000c6, 2, 5);
    measure(`CWR_A_CFG3, 24'h0000c6, 0, 0);
    measure(`CWR_A_OFFS, 24'h000002, 2, 5);
    measure(`CWR_A_GAIN, 24'h000003, 0, 0);
    $display("t_cal done");
  endtask
  task automatic t_delayed();
    measure(`CWR_A_RSVB, 24'h000001, 1024, 1040);
    measure(`CWR_A_RSVC, 24'h000001, 1024, 1040);
    $display("t_delayed done");
  endtask
  task automatic t_stop();
    logic ok;
    wreg(`CWR_A_CFG0, 24'h000020, ok);
    repeat (1100) @(negedge mclk);
    check(conv_on, 1'b0);
    check(sck_oe, 1'b0);
    wreg(`CWR_A_CFG1, 24'h000014, ok);
    repeat (8) @(negedge mclk);
    check(conv_on, 1'b0);
    measure(`CWR_A_CFG0, 24'h000023, 1024, 1040);
    // external clock with a quiet serial clock: pacing must not move
    wreg(`CWR_A_CFG0, 24'h000003, ok);
    repeat (50) @(negedge mclk);
    check(conv_on, 1'b0);
    check(sck_oe, 1'b0);
    measure(`CWR_A_CFG0, 24'h000033, 1024, 1040);
    $display("t_stop done");
  endtask
  task automatic t_lock();
    logic        ok;
    logic [23:0] d;
    wreg(`CWR_A_LOCK, 24'h000000, ok);
    check(ok, 1'b1);
    wreg(`CWR_A_CFG1, 24'h00001c, ok);
    check(ok, 1'b0);
    wreg(4'he, 24'h000001, ok);
    check(ok, 1'b0);
    rreg(`CWR_A_CFG1, d);
    check(d, 24'h000014);
    repeat (200) @(negedge mclk);
    check(crc_flag, 1'b0);
    // the key stays writable while locked, so changing it alters the checksum
    wreg(`CWR_A_LOCK, 24'h000001, ok);
    repeat (40) @(negedge mclk);
    check(crc_flag, 1'b1);
    crc_flag_clr = 1'b1;
    repeat (40) @(negedge mclk);
    crc_flag_clr = 1'b0;
    @(negedge mclk);
    check(crc_flag, 1'b0);
    wreg(`CWR_A_LOCK, 24'h0000a5, ok);
    check(ok, 1'b1);
    $display("t_lock done");
  endtask
  task automatic t_scan();
    logic ok;
    measure(`CWR_A_CFG1, 24'h000000, 2, 5);
    measure(`CWR_A_SCAN, 24'h000003, 2, 5);
    check(seq_pos, 4'h0);
    measure(`CWR_A_MUX, 24'h000002, 0, 0);
    while (seq_pos !== 4'h1) @(negedge mclk);
    measure(`CWR_A_CFG2, 24'h000002, 2, 5);
    check(seq_pos, 4'h1);
    measure(`CWR_A_TIMER, 24'h000005, 0, 0);
    measure(`CWR_A_SCAN, 24'h000003, 2, 5);
    check(seq_pos, 4'h0);
    while (seq_cycle !== 16'h0001) @(negedge mclk);
    wreg(`CWR_A_SCAN, 24'h000003, ok);
    repeat (30) @(negedge mclk);
    check(seq_cycle, 16'h0001);
    while (seq_cycle !== 16'h0002) @(negedge mclk);
    wreg(`CWR_A_TIMER, 24'h000005, ok);
    check(seq_cycle, 16'h0000);
    $display("t_scan done");
  endtask
  task automatic t_spi();
    logic [7:0] rx;
    logic       oe;
    for (int m = 0; m < 2; m++) begin
      tx_byte = m ? 8'ha5 : 8'h96;
      i_host.xfer(m[0], m ? 8'h5a : 8'h3c, 1, rx, oe);
      check(rx, tx_byte);
      check(rx_byte, m ? 8'h5a : 8'h3c);
      check(oe, 1'b1);
      @(negedge mclk);
      check(sdo_oe, 1'b0);
    end
    // 96 under the link polynomial gives 0374; its high byte follows the data
    tx_byte = 8'h96;
    fork
      i_host.xfer(1'b0, 8'h3c, 2, rx, oe);
      begin
        @(posedge rx_vld);
        @(negedge mclk);
        tx_end = 1'b1;
      end
    join
    tx_end = 1'b0;
    check(rx, 8'h03);
    $display("t_spi done");
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_idle();
    t_start();
    t_digital();
    t_immediate();
    t_cal();
    t_delayed();
    t_stop();
    t_lock();
    t_scan();
    t_spi();
    summarize();
  end
endmodule
